//--- logic/uart_aux_pkg.sv
// Purpose: shared constants and carriers for the uart auxiliary control block
// Assumes: one clock domain, synchronous active-high reset
// Notes: register indexes are word offsets on the plain register port
package uart_aux_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CTRL_IDX = 4'h0;
  localparam logic [ADDR_W-1:0] TIME_IDX = 4'h1;
  localparam logic [ADDR_W-1:0] STAT_IDX = 4'h2;
  localparam logic [ADDR_W-1:0] CLR_IDX = 4'h3;
  localparam int TIME_W = 5;
  // control register bit positions
  localparam int TXDMA_BIT = 0;
  localparam int RXDMA_BIT = 1;
  localparam int ERRIE_BIT = 2;
  localparam int RTSEN_BIT = 3;
  localparam int CTSEN_BIT = 4;
  localparam int CTSIRQ_BIT = 5;
  localparam int DRVM_BIT = 6;
  localparam int DRVP_BIT = 7;
  localparam int OVS8_BIT = 8;
  localparam int ESM_BIT = 9;
  localparam int WUIE_BIT = 10;
  localparam int WUSRC_BIT = 11;
  localparam int RXIE_BIT = 12;
  localparam int CTRL_W = 13;
  // time register fields
  localparam int DAT_LSB = 0;
  localparam int DDT_LSB = 8;
  // status and clear bit positions
  localparam int DONE_BIT = 0;
  localparam int CTSF_BIT = 1;
  localparam int WAKEF_BIT = 2;
  localparam int ERRF_BIT = 3;
  localparam int RXF_BIT = 4;
  localparam int TXEMPTY_BIT = 5;
  localparam int STAT_W = 6;
  localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;
  localparam logic [4:0] SAMP16 = 5'h0f;
  localparam logic [4:0] SAMP8 = 5'h07;

  typedef struct packed {
    logic frameErr;
    logic overrunErr;
    logic noiseErr;
  } rx_err_t;

  typedef struct packed {
    logic txReq;
    logic rxReq;
  } dma_req_t;

  typedef enum logic [2:0] {
    DRV_IDLE = 3'b000,
    DRV_ASSERT = 3'b001,
    DRV_SEND = 3'b010,
    DRV_RELEASE = 3'b011
  } drv_state_t;
endpackage

//--- logic/uart_dma_flow_ctrl_wakeup.sv
// Purpose: dma requests, rts/cts flow control, rs485 driver enable, wakeup
// Assumes: frame engine supplies word, frame and oversampling-tick strobes
// Notes: all outputs registered; clkEn freezes every flip-flop
`timescale 1ns/1ps
`default_nettype none
module uart_dma_flow_ctrl_wakeup
  import uart_aux_pkg::*;
#(
  parameter int TIME_BITS = TIME_W
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  input wire logic sampleTick,
  input wire logic txRegWrite,
  input wire logic txLoad,
  input wire logic frameDone,
  input wire logic wordRecv,
  input wire logic rxRead,
  input wire rx_err_t rxErr,
  input wire logic rxLine,
  input wire logic stopMode,
  input wire logic wakeMatch,
  input wire logic wakeReject,
  input wire logic clearToSendIn,
  output dma_req_t dmaReq,
  output logic requestToSendOut,
  output logic txStartOk,
  output logic transceiverDriveOut,
  output logic clockRequest,
  output logic irqOut
);
  // ***********************************************
  // registers
  // ***********************************************
  logic [CTRL_W-1:0] ctrl_r;
  logic [TIME_BITS-1:0] assertTime_r;
  logic [TIME_BITS-1:0] releaseTime_r;
  logic tcFlag_r;
  logic ctsFlag_r;
  logic wakeFlag_r;
  logic errFlag_r;
  logic rxFull_r;
  logic txEmpty_r;
  logic ctsPrev_r;
  logic rxPrev_r;
  logic txPending_r;
  drv_state_t drvState_r;
  logic [TIME_BITS-1:0] unitCnt_r;
  logic [4:0] sampCnt_r;
  logic unitTick;
  logic clrWr;
  logic [STAT_W-1:0] statusVec;

  assign clrWr = regWr && regAddr == CLR_IDX;
  assign statusVec = {txEmpty_r, rxFull_r, errFlag_r, wakeFlag_r,
                      ctsFlag_r, tcFlag_r};

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      ctrl_r <= CTRL_RST;
      assertTime_r <= '0;
      releaseTime_r <= '0;
    end
    else if (clkEn && regWr)
    begin
      if (regAddr == CTRL_IDX)
        ctrl_r <= regWdata[CTRL_W-1:0];
      if (regAddr == TIME_IDX)
      begin
        assertTime_r <= regWdata[DAT_LSB +: TIME_BITS];
        releaseTime_r <= regWdata[DDT_LSB +: TIME_BITS];
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      regRdata <= '0;
    else if (clkEn)
    begin
      regRdata <= '0;
      if (regRd)
        case (regAddr)
          CTRL_IDX: regRdata <= 16'(ctrl_r);
          TIME_IDX: regRdata <= 16'(releaseTime_r) << DDT_LSB
                                | 16'(assertTime_r);
          STAT_IDX: regRdata <= 16'(statusVec);
          default: regRdata <= '0;
        endcase
    end
  end

  // ***********************************************
  // data flags and dma
  // ***********************************************
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      txEmpty_r <= 1'b1;
      txPending_r <= 1'b0;
      rxFull_r <= 1'b0;
      dmaReq <= '0;
    end
    else if (clkEn)
    begin
      if (txRegWrite)
        txEmpty_r <= 1'b0;
      else if (txLoad)
        txEmpty_r <= 1'b1;
      if (txRegWrite)
        txPending_r <= 1'b1;
      else if (txLoad)
        txPending_r <= 1'b0;
      // start-bit wakeup passes no word, so the full flag is untouched
      if (wordRecv && !(stopMode && ctrl_r[WUSRC_BIT]))
        rxFull_r <= 1'b1;
      else if (rxRead)
        rxFull_r <= 1'b0;
      dmaReq.txReq <= ctrl_r[TXDMA_BIT] && txLoad && !txRegWrite;
      dmaReq.rxReq <= ctrl_r[RXDMA_BIT] && wordRecv;
    end
  end

  // ***********************************************
  // status flags, set wins over a clear-register write; a tx write clears tc even with frameDone
  // ***********************************************
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      tcFlag_r <= 1'b1;
      ctsFlag_r <= 1'b0;
      wakeFlag_r <= 1'b0;
      errFlag_r <= 1'b0;
      ctsPrev_r <= 1'b1;
      rxPrev_r <= 1'b1;
    end
    else if (clkEn)
    begin
      ctsPrev_r <= clearToSendIn;
      rxPrev_r <= rxLine;
      // tc rises only when the last frame ends with nothing queued
      if (frameDone && !txPending_r && !txRegWrite)
        tcFlag_r <= 1'b1;
      else if (txRegWrite || (clrWr && regWdata[DONE_BIT]))
        tcFlag_r <= 1'b0;
      if (ctrl_r[CTSEN_BIT] && clearToSendIn != ctsPrev_r)
        ctsFlag_r <= 1'b1;
      else if (clrWr && regWdata[CTSF_BIT])
        ctsFlag_r <= 1'b0;
      if (wakeMatch)
        wakeFlag_r <= 1'b1;
      else if (clrWr && regWdata[WAKEF_BIT])
        wakeFlag_r <= 1'b0;
      if (wordRecv && (rxErr.frameErr || rxErr.overrunErr || rxErr.noiseErr))
        errFlag_r <= 1'b1;
      else if (clrWr && regWdata[ERRF_BIT])
        errFlag_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      irqOut <= 1'b0;
    else if (clkEn)
      irqOut <= (errFlag_r && ctrl_r[ERRIE_BIT])
                || (ctsFlag_r && ctrl_r[CTSIRQ_BIT])
                || (wakeFlag_r && ctrl_r[WUIE_BIT])
                || (rxFull_r && ctrl_r[RXIE_BIT]);
  end

  // ***********************************************
  // flow control
  // ***********************************************
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      requestToSendOut <= 1'b1;
    else if (clkEn)
      requestToSendOut <= ctrl_r[RTSEN_BIT] ? rxFull_r : 1'b0;
  end

  // txStartOk is only consulted at frame start, so a mid-frame rise of
  // cts cannot cut the current frame
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      txStartOk <= 1'b0;
    else if (clkEn)
      txStartOk <= txPending_r
                   && (!ctrl_r[CTSEN_BIT] || !clearToSendIn)
                   && (!ctrl_r[DRVM_BIT] || drvState_r == DRV_SEND);
  end

  // ***********************************************
  // rs485 driver enable
  // ***********************************************
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      sampCnt_r <= '0;
    else if (clkEn && sampleTick)
    begin
      if (sampCnt_r >= (ctrl_r[OVS8_BIT] ? SAMP8 : SAMP16))
        sampCnt_r <= '0;
      else
        sampCnt_r <= sampCnt_r + 5'h01;
    end
  end
  // one sample unit is one oversampling tick
  assign unitTick = sampleTick;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      drvState_r <= DRV_IDLE;
      unitCnt_r <= '0;
    end
    else if (clkEn)
    begin
      case (drvState_r)
        DRV_IDLE:
        begin
          unitCnt_r <= '0;
          if (ctrl_r[DRVM_BIT] && txPending_r)
            drvState_r <= DRV_ASSERT;
        end
        DRV_ASSERT:
        begin
          if (unitCnt_r >= assertTime_r)
          begin
            drvState_r <= DRV_SEND;
            unitCnt_r <= '0;
          end
          else if (unitTick)
            unitCnt_r <= unitCnt_r + 1'b1;
        end
        DRV_SEND:
        begin
          unitCnt_r <= '0;
          if (frameDone && !txPending_r && !txRegWrite)
            drvState_r <= DRV_RELEASE;
        end
        DRV_RELEASE:
        begin
          if (unitCnt_r >= releaseTime_r)
          begin
            unitCnt_r <= '0;
            drvState_r <= txPending_r ? DRV_ASSERT : DRV_IDLE;
          end
          else if (unitTick)
            unitCnt_r <= unitCnt_r + 1'b1;
        end
        default: drvState_r <= DRV_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      transceiverDriveOut <= 1'b0;
    else if (clkEn)
      transceiverDriveOut <= (drvState_r != DRV_IDLE)
                             ^ ctrl_r[DRVP_BIT];
  end

  // ***********************************************
  // stop-mode wakeup clock request
  // ***********************************************
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      clockRequest <= 1'b0;
    else if (clkEn)
    begin
      if (stopMode && ctrl_r[ESM_BIT] && rxPrev_r && !rxLine)
        clockRequest <= 1'b1;
      else if (wakeReject || wakeMatch || !stopMode)
        clockRequest <= 1'b0;
    end
  end

  // ***********************************************
  // checks
  // ***********************************************
  chk_tx_dma: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && ctrl_r[TXDMA_BIT] && txLoad && !txRegWrite
    |=> dmaReq.txReq) else $error("tx dma request missing");
  chk_rx_dma: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && ctrl_r[RXDMA_BIT] && wordRecv
    |=> dmaReq.rxReq) else $error("rx dma request missing");
  chk_tc_low: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && txRegWrite |=> !tcFlag_r)
    else $error("tc not cleared by write");
  chk_err_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && wordRecv && rxErr.frameErr |=> errFlag_r)
    else $error("error flag not raised");
  chk_err_irq: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && errFlag_r && ctrl_r[ERRIE_BIT] |=> irqOut)
    else $error("error interrupt missing");
  chk_rts_level: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && ctrl_r[RTSEN_BIT] |=> requestToSendOut == $past(rxFull_r))
    else $error("rts level wrong");
  chk_cts_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
    txStartOk && ctrl_r[CTSEN_BIT] |-> !$past(clearToSendIn))
    else $error("start allowed with cts high");
  chk_cts_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && ctrl_r[CTSEN_BIT] && clearToSendIn != ctsPrev_r |=> ctsFlag_r)
    else $error("cts change not flagged");
  chk_drv_pol: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && drvState_r == DRV_IDLE
    |=> transceiverDriveOut == $past(ctrl_r[DRVP_BIT]))
    else $error("driver idle level wrong");
  chk_wake_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && wakeMatch |=> wakeFlag_r)
    else $error("wakeup flag not set");
  chk_clk_req: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && stopMode && ctrl_r[ESM_BIT] && rxPrev_r && !rxLine
    |=> clockRequest) else $error("clock not requested");
endmodule
`default_nettype wire

//--- verif/remote_serial_model.sv
// Purpose: far-side serial partner: cts source and rx line driver
// Assumes: bench commands hold-off and start-bit events
// Notes: rx line idles high as with a pull-up
`timescale 1ns/1ps
`default_nettype none
module remote_serial_model
(
  input wire logic core_clk,
  input wire logic holdOff,
  input wire logic wakeEdge,
  output logic clearToSendIn,
  output logic rxLine
);
  logic [3:0] lowCnt;
  initial
  begin
    clearToSendIn = 1'b0;
    rxLine = 1'b1;
    lowCnt = 4'h0;
  end
  // cts changes only on a kernel clock edge
  always @(posedge core_clk)
    clearToSendIn <= holdOff;
  // start bit: line low for eight cycles, then back to idle high
  always @(posedge core_clk)
  begin
    if (wakeEdge)
      lowCnt <= 4'h8;
    else if (lowCnt != 4'h0)
      lowCnt <= lowCnt - 4'h1;
    rxLine <= !(wakeEdge || lowCnt > 4'h1);
  end
endmodule
`default_nettype wire

//--- verif/uart_dma_flow_ctrl_wakeup_tb.sv
// Purpose: self-checking bench for the uart auxiliary control block
// Assumes: bench plays the frame engine and the dma side
// Notes: random values from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module uart_dma_flow_ctrl_wakeup_tb;
  import uart_aux_pkg::*;
  logic core_clk, sys_rst, regWr, regRd, rxLine, clearToSendIn;
  logic stopMode, sampleTick, tickOn, holdOff, wakeEdge;
  logic [ADDR_W-1:0] regAddr;
  logic [15:0] regWdata, regRdata, v;
  logic [6:0] ev;
  rx_err_t rxErr;
  dma_req_t dmaReq;
  logic requestToSendOut, txStartOk, transceiverDriveOut;
  logic clockRequest, irqOut;
  int miscompares, nTests, cycles, ticks, t0, a;
  int seed = 32'hd0dc;
  uart_dma_flow_ctrl_wakeup dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .clkEn(1'b1), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .sampleTick(sampleTick),
    .txRegWrite(ev[0]), .txLoad(ev[1]), .frameDone(ev[2]),
    .wordRecv(ev[3]), .rxRead(ev[4]), .rxErr(rxErr), .rxLine(rxLine),
    .stopMode(stopMode), .wakeMatch(ev[5]), .wakeReject(ev[6]),
    .clearToSendIn(clearToSendIn), .dmaReq(dmaReq),
    .requestToSendOut(requestToSendOut), .txStartOk(txStartOk),
    .transceiverDriveOut(transceiverDriveOut),
    .clockRequest(clockRequest), .irqOut(irqOut));
  remote_serial_model partner (.core_clk(core_clk), .holdOff(holdOff),
    .wakeEdge(wakeEdge), .clearToSendIn(clearToSendIn), .rxLine(rxLine));
  // ************************************************************
  // clock, ticks and hang guard
  // ************************************************************
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles++;
    if (sampleTick)
      ticks++;
    sampleTick <= tickOn & ~sampleTick;
    if (cycles == 20000)
    begin
      miscompares++;
      finalReport;
    end
  end
  // ************************************************************
  // shared tasks
  // ************************************************************
  task check(input string nm, input logic [15:0] seen, exp);
    nTests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [3:0] ad, input logic [15:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= ad;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task rd(input logic [3:0] ad);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= ad;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask
  task pulse(input int i);
    @(posedge core_clk);
    ev[i] <= 1'b1;
    @(posedge core_clk);
    ev[i] <= 1'b0;
    #1;
  endtask
  task idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task startBit;
    @(posedge core_clk);
    wakeEdge <= 1'b1;
    @(posedge core_clk);
    wakeEdge <= 1'b0;
    idle(3);
  endtask
  task done(input string nm);
    $display("test %s done", nm);
  endtask
  task finalReport;
    $display("checks %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    {regWr, regRd, stopMode, tickOn, holdOff, wakeEdge} = '0;
    regAddr = '0;
    regWdata = '0;
    ev = '0;
    rxErr = '0;
    sys_rst = 1'b1;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    idle(1);
    check("drive idle", transceiverDriveOut, 0);
    check("irq idle", irqOut, 0);
    rd(STAT_IDX);
    check("status reset", v, 16'h0021);
    done("reset");
    repeat (4)
    begin
      a = $random(seed);
      wr(CTRL_IDX, a[15:0]);
      rd(CTRL_IDX);
      check("ctrl", v, a[15:0] & 16'h1fff);
    end
    wr(TIME_IDX, 16'hffff);
    rd(TIME_IDX);
    check("time fields", v, 16'h1f1f);
    rd(4'hf);
    check("unmapped", v, 0);
    wr(CTRL_IDX, 16'h0003);
    pulse(1);
    check("tx dma", dmaReq.txReq, 1);
    pulse(3);
    check("rx dma", dmaReq.rxReq, 1);
    pulse(4);
    wr(CTRL_IDX, 16'h0000);
    pulse(1);
    check("tx dma off", dmaReq.txReq, 0);
    done("dma");
    wr(CLR_IDX, 16'h0001);
    pulse(0);
    pulse(1);
    rd(STAT_IDX);
    check("tc busy", v[DONE_BIT], 0);
    pulse(2);
    rd(STAT_IDX);
    check("tc end", v[DONE_BIT], 1);
    done("tc");
    wr(CTRL_IDX, 16'h0004);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge core_clk);
      rxErr <= rx_err_t'(3'b001 << i);
      pulse(3);
      rxErr <= '0;
      rd(STAT_IDX);
      check("err flag", v[ERRF_BIT], 1);
      check("err irq", irqOut, 1);
      wr(CLR_IDX, 16'h0008);
      pulse(4);
      idle(2);
      check("err irq off", irqOut, 0);
    end
    done("errors");
    wr(CTRL_IDX, 16'h0008);
    idle(2);
    check("rts ready", requestToSendOut, 0);
    pulse(3);
    idle(2);
    check("rts full", requestToSendOut, 1);
    pulse(4);
    idle(2);
    check("rts drained", requestToSendOut, 0);
    done("rts");
    wr(CTRL_IDX, 16'h0030);
    @(posedge core_clk);
    holdOff <= 1'b1;
    pulse(0);
    idle(3);
    rd(STAT_IDX);
    check("cts flag", v[CTSF_BIT], 1);
    check("cts irq", irqOut, 1);
    check("cts held", txStartOk, 0);
    @(posedge core_clk);
    holdOff <= 1'b0;
    idle(4);
    check("cts free", txStartOk, 1);
    pulse(1);
    pulse(2);
    wr(CLR_IDX, 16'h0002);
    done("cts");
    for (int p = 0; p < 2; p++)
    begin
      a = p ? 31 : ($random(seed) & 30) + 1;
      wr(TIME_IDX, {3'b000, a[4:0], 3'b000, a[4:0]});
      wr(CTRL_IDX, 16'h0040 | 16'(p << 7));
      idle(1);
      check("drive off", transceiverDriveOut, p[0]);
      @(posedge core_clk);
      tickOn <= 1'b1;
      pulse(0);
      t0 = ticks;
      for (int k = 0; k < 400 && txStartOk !== 1'b1; k++)
        @(posedge core_clk);
      #1;
      check("drive on", transceiverDriveOut, !p[0]);
      check("assert time", ticks - t0 >= a && ticks - t0 <= a + 1, 1);
      pulse(1);
      pulse(0);
      pulse(2);
      idle(4);
      check("drive held", transceiverDriveOut, !p[0]);
      pulse(1);
      pulse(2);
      t0 = ticks;
      for (int k = 0; k < 400 && transceiverDriveOut !== p[0]; k++)
        @(posedge core_clk);
      #1;
      check("release time", ticks - t0 >= a && ticks - t0 <= a + 1, 1);
      @(posedge core_clk);
      tickOn <= 1'b0;
    end
    done("driver");
    wr(CTRL_IDX, 16'h0600);
    @(posedge core_clk);
    stopMode <= 1'b1;
    startBit;
    check("clock req", clockRequest, 1);
    pulse(6);
    idle(1);
    check("clock released", clockRequest, 0);
    startBit;
    pulse(5);
    rd(STAT_IDX);
    check("wake flag", v[WAKEF_BIT], 1);
    check("wake irq", irqOut, 1);
    wr(CLR_IDX, 16'h0004);
    @(posedge core_clk);
    stopMode <= 1'b0;
    pulse(5);
    rd(STAT_IDX);
    check("wake active", v[WAKEF_BIT], 1);
    wr(CLR_IDX, 16'h0004);
    wr(CTRL_IDX, 16'h0a00);
    @(posedge core_clk);
    stopMode <= 1'b1;
    pulse(3);
    rd(STAT_IDX);
    check("start-bit no rx", v[RXF_BIT], 0);
    done("wakeup");
    finalReport;
  end
endmodule
`default_nettype wire
